// ### design/sep_eeprom.sv
// Purpose: Device logic of a three-wire serial EEPROM with x8/x16 organisation
// Assumes: Serial clock much slower than clock (period of 8 cycles or more)
// Notes: Read data is prefetched into a FIFO ahead of the serial shifter
`default_nettype none

// ------------------------------------------------------------------
// Read-data FIFO
// ------------------------------------------------------------------
module sep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sep_fifo_st_t;
  sep_fifo_st_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end

  assign in_ready = q.cnt != DEPTH[PW:0];
  assign out_valid = q.cnt != '0;
  assign out_data = mem[q.rp];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_comb begin
    d = q;
    if (flush) begin
      d = '0;
    end else begin
      if (push) d.wp = q.wp + 1'b1;
      if (pop) d.rp = q.rp + 1'b1;
      d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) q <= '0;
    else q <= d;
    if (push) mem[q.wp] <= in_data;
  end
endmodule

// ------------------------------------------------------------------
// Device top
// ------------------------------------------------------------------
// What this block does
// [R1] Width-select high gives x16, low gives x8
// [R2] Array size from address-width parameter
// [R3] Decode read, write, erase, erase-all, write-all
// [R4] Read loads pointer, shifts location out
// [R5] Pointer increments; output continues while selected
// [R6] Pointer wraps to zero past top
// [R7] Sequential read any length, ends on deselect
// [R8] Programming self-timed, serial clock ignored
// [R9] Write overwrites location, no erase needed
// [R10] One write programs one byte or word
// [R11] Busy/ready shown on output while selected
// [R12] Reset clears programming, enters write-disabled
// [R13] Supply-low detector blocks every operation
// [R14] Host keeps select low during power ramps
// [R15] Input sampled on serial clock rising edge
// [R16] Word mode uses one fewer address bit
// [R17] Write-disabled ignores writes and erases
module sep_eeprom #(
  parameter int AW8 = sep_pkg::ABITS_X8,
  parameter int PROG_CYC = sep_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic width_select,
  input wire logic power_ok,
  output logic sdo,
  output logic sdo_oe
);
  import sep_pkg::*;

  localparam logic [AW8-1:0] TOP8 = '1;
  localparam logic [AW8-1:0] TOP16 = {1'b0, {(AW8-1){1'b1}}};

  typedef struct packed {
    logic [2:0] sel_s;
    logic [2:0] clk_s;
    logic [1:0] din_s;
    logic [1:0] wsel_s;
    logic [1:0] pwr_s;
    sep_state_t st;
    logic [4:0] cnt;
    logic [1:0] op;
    logic [AW8-1:0] addr;
    logic [15:0] wd;
    logic we;
    logic [31:0] timer;
    logic [AW8-1:0] pa;
    logic [AW8-1:0] pend;
    logic [AW8-1:0] rptr;
    logic [15:0] osh;
    logic [4:0] oleft;
    logic sdo;
    logic sdo_oe;
  } sep_st_t;
  sep_st_t q, d;

  logic [7:0] mem [2**AW8];
  logic x16, sel_h, sel_fall, rise, din, pwr;
  logic [4:0] abits, dbits;
  logic [AW8-1:0] top, a_full;
  logic [1:0] sub;
  logic [15:0] rword;
  logic f_in_valid, f_in_ready, f_out_valid, f_pop, f_flush;
  logic [15:0] f_out_data;
  logic mem_we;
  logic [7:0] mem_wdata;

  if (AW8 < 5 || AW8 > 11) begin : g_bad_aw8
    $error("AW8 must be 5 to 11");
  end
  if (PROG_CYC < 1) begin : g_bad_prog
    $error("PROG_CYC must be at least 1");
  end

  // ----------------------------------------------------------------
  // Pin view and decode helpers
  // ----------------------------------------------------------------
  assign x16 = q.wsel_s[1]; // [R1]
  assign sel_h = q.sel_s[1];
  assign sel_fall = q.sel_s[2] && !q.sel_s[1];
  assign rise = q.clk_s[1] && !q.clk_s[2] && sel_h; // [R15]
  assign din = q.din_s[1];
  assign pwr = q.pwr_s[1];
  assign abits = x16 ? 5'(AW8 - 1) : 5'(AW8); // [R16]
  assign dbits = x16 ? 5'd16 : 5'd8; // [R10]
  assign top = x16 ? TOP16 : TOP8; // [R2]
  assign a_full = {q.addr[AW8-2:0], din};
  assign sub = x16 ? a_full[AW8-2 -: 2] : a_full[AW8-1 -: 2];
  // Word locations pair an even low byte with the odd high byte
  assign rword = x16 ? {mem[{q.rptr[AW8-2:0], 1'b1}], mem[{q.rptr[AW8-2:0], 1'b0}]}
                     : {mem[q.rptr], 8'h00};
  assign f_in_valid = q.st == ST_RDATA;
  assign f_flush = q.st != ST_RDATA;
  assign f_pop = q.st == ST_RDATA && rise && q.oleft == 5'd0;

  sep_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .flush(f_flush),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(rword),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  // ----------------------------------------------------------------
  // Array write port, fed by the programming walk
  // ----------------------------------------------------------------
  assign mem_we = q.st == ST_PROG && q.timer == 32'(PROG_CYC);
  always_comb begin
    mem_wdata = ERASED_BYTE;
    if (q.op == OP_WRITE || (q.op == OP_SPECIAL && q.addr[0])) begin
      mem_wdata = (x16 && q.pa[0]) ? q.wd[15:8] : q.wd[7:0]; // [R9]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.sel_s = {q.sel_s[1:0], sel};
    d.clk_s = {q.clk_s[1:0], sclk};
    d.din_s = {q.din_s[0], sdi};
    d.wsel_s = {q.wsel_s[0], width_select};
    d.pwr_s = {q.pwr_s[0], power_ok};
    d.sdo_oe = 1'b0;
    if (f_in_valid && f_in_ready) d.rptr = (q.rptr + 1'b1) & top; // [R5] [R6]
    case (q.st)
      ST_IDLE: begin
        d.cnt = 5'd0;
        d.addr = '0;
        if (rise && din) d.st = ST_CMD;
      end
      ST_CMD: begin
        if (rise) begin
          d.cnt = q.cnt + 5'd1;
          if (q.cnt < 5'd2) d.op = {q.op[0], din};
          else d.addr = a_full;
          if (q.cnt == abits + 5'd1) begin
            d.cnt = 5'd0;
            d.st = ST_WAIT;
            d.addr = a_full & top;
            case (q.op) // [R3]
              OP_READ: begin
                d.st = ST_RDATA; // [R4]
                d.rptr = a_full & top;
                d.oleft = 5'd0;
                d.sdo = 1'b0;
              end
              OP_WRITE: if (q.we) d.st = ST_WDATA; // [R17]
              OP_ERASE: if (q.we) d.st = ST_ARMED; // [R17]
              OP_SPECIAL: begin
                case (sub)
                  SUB_ENABLE: d.we = 1'b1;
                  SUB_DISABLE: d.we = 1'b0;
                  SUB_ERASE_ALL: if (q.we) d.st = ST_ARMED; // [R17]
                  SUB_WRITE_ALL: if (q.we) d.st = ST_WDATA; // [R17]
                  default: d.st = ST_WAIT;
                endcase
                d.addr = {{(AW8-1){1'b0}}, sub == SUB_WRITE_ALL};
              end
              default: d.st = ST_WAIT;
            endcase
          end
        end
      end
      ST_RDATA: begin
        d.sdo_oe = 1'b1;
        if (rise) begin
          if (q.oleft == 5'd0) begin
            if (f_out_valid) begin
              d.sdo = f_out_data[15];
              d.osh = {f_out_data[14:0], 1'b0};
              d.oleft = dbits - 5'd1;
            end
          end else begin
            d.sdo = q.osh[15];
            d.osh = {q.osh[14:0], 1'b0};
            d.oleft = q.oleft - 5'd1;
          end
        end
      end
      ST_WDATA: begin
        if (rise) begin
          d.wd = {q.wd[14:0], din};
          d.cnt = q.cnt + 5'd1;
          if (q.cnt == dbits - 5'd1) d.st = ST_ARMED; // [R10]
        end
      end
      ST_ARMED: begin
        // Programming starts on deselect; the range to walk is fixed here
        if (sel_fall) begin
          d.st = ST_PROG;
          d.timer = 32'd0;
          if (q.op == OP_SPECIAL) begin
            d.pa = '0;
            d.pend = TOP8;
          end else if (x16) begin
            d.pa = {q.addr[AW8-2:0], 1'b0};
            d.pend = {q.addr[AW8-2:0], 1'b1};
          end else begin
            d.pa = q.addr;
            d.pend = q.addr;
          end
          if (!x16) d.wd = {q.wd[7:0], q.wd[7:0]};
        end
      end
      ST_PROG: begin
        // The serial clock is not looked at here, so it may stop or run
        d.sdo_oe = sel_h; // [R11]
        d.sdo = 1'b0;
        if (q.timer != 32'(PROG_CYC)) begin
          d.timer = q.timer + 32'd1; // [R8]
        end else begin
          d.pa = q.pa + 1'b1;
          if (q.pa == q.pend) d.st = ST_RDY;
        end
      end
      ST_RDY: begin
        d.sdo_oe = sel_h; // [R11]
        d.sdo = 1'b1;
        if (sel_fall) d.st = ST_IDLE;
      end
      ST_WAIT: begin
        if (!sel_h) d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase
    // A partial instruction is dropped when select falls
    if (!sel_h && (q.st == ST_CMD || q.st == ST_RDATA || q.st == ST_WDATA)) begin
      d.st = ST_IDLE; // [R7]
      d.sdo_oe = 1'b0;
    end
    if (!pwr) begin
      d.st = ST_IDLE; // [R13]
      d.we = RESET_WE;
      d.sdo_oe = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0; // [R12]
      q.st <= ST_IDLE;
      q.we <= RESET_WE; // [R12]
    end else begin
      q <= d;
    end
    if (rstn && pwr && mem_we) mem[q.pa] <= mem_wdata;
  end

  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;
endmodule
`default_nettype wire

// ### shared/sep_pkg.sv
// Purpose: Constants for the serial EEPROM device logic
// Assumes: 100 MHz system clock
// Notes: Opcode encodings are local choices
`default_nettype none
package sep_pkg;
  // ----------------------------------------------------------------
  // Array and timing
  // ----------------------------------------------------------------
  localparam int ABITS_X8 = 11;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 5_000_000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic RESET_WE = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_RDATA, ST_WDATA, ST_ARMED, ST_WAIT, ST_PROG, ST_RDY
  } sep_state_t;
endpackage
`default_nettype wire

// ### verif/sep_eeprom_chk.sv
// Purpose: Port checks for sep_eeprom
// Assumes: Pins synced in two flops
// Notes: Bound to every instance
`default_nettype none
module sep_eeprom_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sel,
  input wire logic sclk,
  input wire logic power_ok,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  // Cycles since the serial clock rose, saturating
  always_comb begin
    age_d = age_q + {3'h0, age_q != 4'hf};
    if (sclk && !sclk_q) age_d = 4'h0;
  end
  always_ff @(posedge clock) begin
    sclk_q <= sclk;
    age_q <= rstn ? age_d : 4'hf;
  end
  sequence s_held;
    (sel && power_ok) [*4];
  endsequence
  sequence s_desel;
    (!sel) [*5];
  endsequence
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_RST_QUIET: assert property (disable iff (1'b0) !rstn |=> !sdo_oe && !sdo)
    else $error("output after reset");
  AST_PWR_BLOCK: assert property ((!power_ok) [*5] |-> !sdo_oe)
    else $error("output at low supply");
  AST_OE_PWR: assert property ($rose(sdo_oe) |-> $past(power_ok, 2))
    else $error("enable at low supply");
  AST_DESEL: assert property (s_desel |-> !sdo_oe)
    else $error("output while deselected");
  AST_OE_SEL: assert property ($rose(sdo_oe) |-> $past(sel, 2))
    else $error("enable without select");
  AST_HELD: assert property (s_held ##0 sdo_oe |=> sdo_oe)
    else $error("output dropped");
  AST_SDO_EDGE: assert property (sdo_oe && $past(sdo_oe) && $fell(sdo) |-> age_q < 4'h8)
    else $error("data moved off clock");
  AST_READY: assert property (sdo_oe && $rose(sdo) && age_q > 4'h9 |=> (sdo && sdo_oe) [*2])
    else $error("ready not held");
endmodule
bind sep_eeprom sep_eeprom_chk u_chk (
  .clock(clock), .rstn(rstn), .sel(sel), .sclk(sclk),
  .power_ok(power_ok), .sdo(sdo), .sdo_oe(sdo_oe)
);
`default_nettype wire

// ### verif/sep_host_model.sv
// Purpose: Host driving select, serial clock, data
// Assumes: Half period of half cycles, 8 or more
// Notes: Released data line shows its inverse
`default_nettype none
module sep_host_model (
  input wire logic clock,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sel,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  int half = 8;
  initial begin
    sel = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic tick(input logic b);
    sdi = b;
    cyc(half);
    sclk = 1'b1;
    cyc(half);
    sclk = 1'b0;
  endtask
  task automatic bits(input logic [15:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) tick(d[i]);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [10:0] a, input int na);
    sel = 1'b1;
    cyc(4);
    tick(1'b1);
    bits({14'h0, op}, 2);
    bits({5'h0, a}, na);
  endtask
  // Sampled late in the bit, once it has settled
  task automatic rd(input int n, output logic [15:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      tick(~sdi);
      v = {v[14:0], sdo_oe ? sdo : ~sdo};
    end
  endtask
  task automatic done();
    sel = 1'b0;
    sdi = ~sdi;
    cyc(6);
  endtask
  task automatic poll(output logic [1:0] st, output logic rdy);
    sel = 1'b1;
    cyc(5);
    st = {sdo_oe, sdo};
    rdy = 1'b0;
    for (int i = 0; i < 600 && !rdy; i++) begin
      cyc(1);
      rdy = sdo_oe && sdo;
    end
    cyc(1);
    done();
  endtask
endmodule
`default_nettype wire

// ### verif/serial_eeprom_device_logic_tb_top.sv
// Purpose: Self-checking bench for sep_eeprom
// Assumes: 32-byte array, short programming
// Notes: Expected contents held in mem
`default_nettype none
module serial_eeprom_device_logic_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sep_pkg::*;
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic width_select = 1'b0;
  logic power_ok = 1'b1;
  logic sel, sclk, sdi, sdo, sdo_oe, rdy;
  int n_mismatch = 0;
  int comparisons = 0;
  logic we = 1'b0;
  logic [7:0] mem [32];
  logic [15:0] v;
  logic [1:0] st;
  always #5 clock = ~clock;
  // Programming outlasts the idle clock burst and poll set-up, so busy is seen
  sep_eeprom #(.AW8(5), .PROG_CYC(60)) dut (
    .clock(clock), .rstn(rstn), .sel(sel), .sclk(sclk), .sdi(sdi),
    .width_select(width_select), .power_ok(power_ok), .sdo(sdo), .sdo_oe(sdo_oe)
  );
  sep_host_model h (
    .clock(clock), .sdo(sdo), .sdo_oe(sdo_oe), .sel(sel), .sclk(sclk), .sdi(sdi)
  );
  function automatic int na();
    return width_select ? 4 : 5;
  endfunction
  function automatic logic [15:0] exp_at(input int k);
    if (width_select) return {mem[(2 * k + 1) % 32], mem[(2 * k) % 32]};
    return {8'h00, mem[k % 32]};
  endfunction
  task automatic special(input logic [1:0] sub);
    h.cmd(OP_SPECIAL, 11'(sub) << (na() - 2), na());
    h.done();
    we = (sub == SUB_ENABLE);
  endtask
  task automatic prog(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d);
    logic [1:0] sub;
    logic all;
    sub = 2'(a >> (na() - 2));
    all = (op == OP_SPECIAL);
    h.cmd(op, a, na());
    if (op == OP_WRITE || (all && sub == SUB_WRITE_ALL)) h.bits(d, 8 << width_select);
    h.done();
    h.tick(1'b1);
    h.poll(st, rdy);
    if (we) begin
      `CHK("busy", 2'b10, st)
      `CHK("ready", 1'b1, rdy)
    end else begin
      `CHK("refused", 1'b0, st[1])
    end
    for (int i = 0; i < 32; i++) begin
      if (we && (all || (width_select ? i / 2 == a : i == a))) begin
        if (op == OP_ERASE || (all && sub == SUB_ERASE_ALL)) mem[i] = ERASED_BYTE;
        else mem[i] = (width_select && i % 2 == 1) ? d[15:8] : d[7:0];
      end
    end
  endtask
  task automatic rd(input logic [10:0] a, input int n);
    h.cmd(OP_READ, a, na());
    for (int k = 0; k < n; k++) begin
      h.rd(8 << width_select, v);
      `CHK("read data", exp_at(a + k), v)
    end
    h.done();
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    logic [10:0] a;
    logic [10:0] msk;
    void'($urandom(32'h495f_234f));
    h.cyc(4);
    rstn = 1'b1;
    h.cyc(2);
    `CHK("idle", 1'b0, sdo_oe)
    prog(OP_SPECIAL, 11'h008, 16'h005a);
    special(SUB_ENABLE);
    prog(OP_SPECIAL, 11'h008, 16'h00c3);
    rd(11'h000, 33);
    $display("test write-all done");
    for (int k = 0; k < 8; k++) begin
      h.half = 8 + $urandom_range(4);
      width_select = 1'($urandom);
      h.cyc(4);
      msk = width_select ? 11'h00f : 11'h01f;
      a = ((k == 0) ? 11'h01f : 11'($urandom_range(31))) & msk;
      prog(OP_WRITE, a, 16'($urandom));
      if (k % 3 == 1) prog(OP_ERASE, (a + 11'h001) & msk, 16'h0000);
      rd(a, 3);
    end
    $display("test random done");
    width_select = 1'b1;
    h.cyc(4);
    a = 11'($urandom_range(15));
    prog(OP_WRITE, a, 16'($urandom));
    rd(a, 2);
    prog(OP_SPECIAL, 11'h004, 16'h9e37);
    width_select = 1'b0;
    h.cyc(4);
    rd(11'h01e, 4);
    $display("test word done");
    special(SUB_DISABLE);
    prog(OP_WRITE, 11'h003, 16'h0012);
    prog(OP_ERASE, 11'h004, 16'h0000);
    prog(OP_SPECIAL, 11'h010, 16'h0000);
    rd(11'h002, 3);
    special(SUB_ENABLE);
    prog(OP_SPECIAL, 11'h010, 16'h0000);
    rd(11'h01f, 2);
    $display("test disable done");
    h.cmd(OP_WRITE, 11'h007, 5);
    h.bits(16'h0044, 8);
    h.done();
    power_ok = 1'b0;
    h.sel = 1'b1;
    h.cyc(8);
    `CHK("low supply", 1'b0, sdo_oe)
    h.done();
    power_ok = 1'b1;
    h.cyc(4);
    we = 1'b0;
    mem[7] = 8'hxx;
    prog(OP_WRITE, 11'h009, 16'h0021);
    rd(11'h008, 2);
    // Reset in mid-run must drop write enable again
    special(SUB_ENABLE);
    rstn = 1'b0;
    h.cyc(4);
    rstn = 1'b1;
    h.cyc(2);
    `CHK("reset quiet", 1'b0, sdo_oe)
    we = 1'b0;
    prog(OP_WRITE, 11'h00a, 16'h0055);
    rd(11'h00a, 1);
    $display("test supply done");
    summarize();
  end
  initial begin
    #900_000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
